// ===== inc/thermal_pkg.sv
package thermal_pkg;
	localparam int NUM_CORES = 4;
	localparam int CORE_W = 2;
	localparam int TEMP_W = 7;
	localparam int PWR_W = 15;
	localparam int ADDR_W = 12;
	localparam int TIME_W = 7;

	localparam logic [ADDR_W-1:0] ADDR_THR_CTRL = 12'h19B;
	localparam logic [ADDR_W-1:0] ADDR_CORE_STATUS = 12'h19C;
	localparam logic [ADDR_W-1:0] ADDR_TEMP_REF = 12'h1A2;
	localparam logic [ADDR_W-1:0] ADDR_PKG_STATUS = 12'h1B1;
	localparam logic [ADDR_W-1:0] ADDR_PWR_CAP = 12'h610;
	localparam logic [ADDR_W-1:0] ADDR_PWR_RATING = 12'h614;

	localparam int ST_TCC = 0;
	localparam int ST_TCC_LOG = 1;
	localparam int ST_OOS = 4;
	localparam int ST_THR1 = 6;
	localparam int ST_THR1_LOG = 7;
	localparam int ST_THR2 = 8;
	localparam int ST_THR2_LOG = 9;
	localparam int ST_READ_LSB = 16;
	localparam int THR1_LSB = 8;
	localparam int THR1_EN = 15;
	localparam int THR2_LSB = 16;
	localparam int THR2_EN = 23;
	localparam int REF_LSB = 16;
	localparam int CAP_PL1_LSB = 0;
	localparam int CAP_CLAMP = 16;
	localparam int CAP_TIME_LSB = 17;
	localparam int CAP_PL2_LSB = 32;

	localparam logic [7:0] TJMAX_C = 8'h64;
	localparam logic [PWR_W-1:0] TDP_UNITS = 15'h0258;
	localparam logic [PWR_W-1:0] PL2_RESET = TDP_UNITS + (TDP_UNITS >> 2);
	localparam logic [TIME_W-1:0] TIME_RESET = 7'h01;
	localparam logic [TEMP_W-1:0] TCC_ACT_READING = 7'h00;
	localparam logic [TEMP_W-1:0] OOS_RISE_STEP = 7'h05;
	localparam logic [TEMP_W-1:0] THR_RESET = 7'h00;

	localparam int CLK_PERIOD_NS = 40;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int TICK_W = 16;
	localparam int AVG_WINDOW_MS = 256;
	localparam int AVG_ADDR_W = 8;
	localparam int AVG_SUM_W = 15;
	localparam int EXCURSION_MS = 10;
	localparam logic [3:0] EXCURSION_LIMIT = 4'(EXCURSION_MS - 1);
	localparam int MS_PER_SEC = 1000;
	localparam int WIN_MS_W = 17;
	localparam int EWMA_FRAC = 20;
	localparam int ACC_W = 40;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [CORE_W-1:0] core;
		logic [63:0] wdata;
	} msr_req_t;

	typedef enum logic [1:0] {
		AVG_IDLE = 2'b00,
		AVG_READ = 2'b01,
		AVG_SUM = 2'b11
	} avg_state_t;

	typedef struct packed {
		logic [PWR_W-1:0] pl1;
		logic clamp;
		logic [TIME_W-1:0] win;
		logic [PWR_W-1:0] pl2;
	} cap_cfg_t;

	typedef struct packed {
		logic [ACC_W-1:0] acc;
		logic [3:0] over_ms;
		logic long_limit;
		logic short_limit;
		logic below_ok;
	} gov_state_t;

	typedef struct packed {
		logic [NUM_CORES-1:0][TEMP_W-1:0] s1_temp;
		logic [NUM_CORES-1:0][TEMP_W-1:0] s2_temp;
		logic s1_trip;
		logic s2_trip;
		logic shutdown;
		logic [TICK_W-1:0] tick_cnt;
		logic tick;
		avg_state_t avg_st;
		logic [AVG_ADDR_W-1:0] wptr;
		logic filled;
		logic [TEMP_W-1:0] sample;
		logic [AVG_SUM_W-1:0] sum;
		logic [TEMP_W-1:0] sideband;
		logic [TEMP_W-1:0] prev_pkg;
		logic thermal_control_circuit;
		logic tcc_log;
		logic oos;
		logic [1:0] thr_state;
		logic [1:0] thr_log;
		logic [1:0] thr_en;
		logic [1:0][TEMP_W-1:0] thr_val;
		cap_cfg_t cap;
		logic throttle;
		logic below_base;
		logic irq;
		logic [63:0] rdata;
		logic ack;
	} mon_state_t;
endpackage

// ===== hw/temp_sample_ram.sv
`timescale 1ns/1ps
`default_nettype none
module temp_sample_ram
	import thermal_pkg::*;
(
	input wire logic ref_clk,
	input wire logic wr_en,
	input wire logic [AVG_ADDR_W-1:0] wr_addr,
	input wire logic [TEMP_W-1:0] wr_data,
	input wire logic [AVG_ADDR_W-1:0] rd_addr,
	output logic [TEMP_W-1:0] rd_data
);
	logic [TEMP_W-1:0] mem [AVG_WINDOW_MS];

	// No reset: contents are ignored until the ring has wrapped once
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// ===== hw/power_governor.sv
`timescale 1ns/1ps
`default_nettype none
module power_governor
	import thermal_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic [PWR_W-1:0] power,
	input wire logic turbo_en,
	input wire cap_cfg_t cap,
	output logic long_limit,
	output logic short_limit,
	output logic below_ok
);
	gov_state_t r, next_r;
	logic [WIN_MS_W-1:0] win_ms;
	logic [4:0] shift;
	logic signed [ACC_W:0] diff;
	logic [PWR_W-1:0] avg;
	logic [PWR_W-1:0] long_cap;

	always_comb begin
		next_r = r;
		win_ms = WIN_MS_W'(cap.win * MS_PER_SEC);
		shift = 5'h00;
		// Time constant in ms rounded up to a power of two
		for (int i = 0; i < WIN_MS_W; i++) begin
			if (win_ms[i]) begin
				shift = 5'(i + 1);
			end
		end
		diff = $signed({1'b0, ACC_W'({power, EWMA_FRAC'(0)})}) - $signed({1'b0, r.acc});
		avg = r.acc[EWMA_FRAC +: PWR_W];
		long_cap = turbo_en ? cap.pl1 : TDP_UNITS;
		if (tick) begin
			next_r.acc = ACC_W'($signed({1'b0, r.acc}) + (diff >>> shift));
			if (power > cap.pl2) begin
				if (r.over_ms != EXCURSION_LIMIT) begin
					next_r.over_ms = r.over_ms + 4'h1;
				end
			end else begin
				next_r.over_ms = 4'h0;
			end
		end
		next_r.long_limit = avg > long_cap;
		next_r.short_limit = (power > cap.pl2) && (r.over_ms == EXCURSION_LIMIT);
		next_r.below_ok = turbo_en && cap.clamp && (cap.pl1 < TDP_UNITS);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign long_limit = r.long_limit;
	assign short_limit = r.short_limit;
	assign below_ok = r.below_ok;
endmodule
`default_nettype wire

// ===== hw/thermal_power_limit_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module thermal_power_limit_monitor
	import thermal_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [NUM_CORES-1:0][TEMP_W-1:0] sensor_reading,
	input wire logic overheat_trip,
	input wire logic [PWR_W-1:0] package_power,
	input wire logic turbo_en,
	input wire msr_req_t msr_req,
	output logic [63:0] msr_rdata,
	output logic msr_ack,
	output logic threshold_irq,
	output logic throttle_cores,
	output logic throttle_gfx,
	output logic allow_below_base,
	output logic shutdown,
	output logic [TEMP_W-1:0] sideband_temp
);
	mon_state_t r, next_r;
	logic [TEMP_W-1:0] pkg_min;
	logic [TEMP_W-1:0] ram_rdata;
	logic ram_wr;
	logic gov_long;
	logic gov_short;
	logic gov_below;
	logic [1:0] thr_now;
	logic tcc_now;
	logic oos_now;
	logic [63:0] rd_word;
	logic [63:0] wd;

	temp_sample_ram temp_sample_ram_i (
		.ref_clk(ref_clk),
		.wr_en(ram_wr),
		.wr_addr(r.wptr),
		.wr_data(r.sample),
		.rd_addr(r.wptr),
		.rd_data(ram_rdata)
	);

	power_governor power_governor_i (
		.ref_clk(ref_clk),
		.rst(rst),
		.tick(r.tick),
		.power(package_power),
		.turbo_en(turbo_en),
		.cap(r.cap),
		.long_limit(gov_long),
		.short_limit(gov_short),
		.below_ok(gov_below)
	);

	// Status word shared by core and package views
	function automatic logic [63:0] status_word(input logic [TEMP_W-1:0] reading,
			input mon_state_t s);
		logic [63:0] w;
		w = '0;
		w[ST_TCC] = s.thermal_control_circuit;
		w[ST_TCC_LOG] = s.tcc_log;
		w[ST_OOS] = s.oos;
		w[ST_THR1] = s.thr_state[0];
		w[ST_THR1_LOG] = s.thr_log[0];
		w[ST_THR2] = s.thr_state[1];
		w[ST_THR2_LOG] = s.thr_log[1];
		w[ST_READ_LSB +: TEMP_W] = reading;
		return w;
	endfunction

	assign ram_wr = (r.avg_st == AVG_SUM);

	always_comb begin
		next_r = r;
		wd = msr_req.wdata;
		rd_word = '0;

		// Sensor readings and the overheat trip pass two flops first; package_power and turbo_en do not
		next_r.s1_temp = sensor_reading;
		next_r.s2_temp = r.s1_temp;
		next_r.s1_trip = overheat_trip;
		next_r.s2_trip = r.s1_trip;

		// Smallest offset is the hottest sensor
		pkg_min = r.s2_temp[0];
		for (int i = 1; i < NUM_CORES; i++) begin
			if (r.s2_temp[i] < pkg_min) begin
				pkg_min = r.s2_temp[i];
			end
		end

		// Comparator level is fixed in silicon; no register touches it
		if (r.s2_trip) begin
			next_r.shutdown = 1'b1;
		end

		next_r.tick = 1'b0;
		if (r.tick_cnt == TICK_W'(TICK_LEN - 1)) begin
			next_r.tick_cnt = '0;
			next_r.tick = 1'b1;
		end else begin
			next_r.tick_cnt = r.tick_cnt + 1'b1;
		end

		// Sliding window: add newest, drop the sample 256 ticks old
		unique case (r.avg_st)
			AVG_IDLE: begin
				if (r.tick) begin
					next_r.sample = pkg_min;
					next_r.avg_st = AVG_READ;
				end
			end
			AVG_READ: begin
				next_r.avg_st = AVG_SUM;
			end
			AVG_SUM: begin
				next_r.sum = r.sum + AVG_SUM_W'(r.sample)
					- (r.filled ? AVG_SUM_W'(ram_rdata) : AVG_SUM_W'(0));
				next_r.sideband = next_r.sum[AVG_SUM_W-1 -: TEMP_W];
				next_r.wptr = r.wptr + 1'b1;
				if (r.wptr == '1) begin
					next_r.filled = 1'b1;
				end
				next_r.avg_st = AVG_IDLE;
			end
			default: begin
				next_r.avg_st = AVG_IDLE;
			end
		endcase

		tcc_now = (pkg_min <= TCC_ACT_READING);
		oos_now = 1'b0;
		if (r.tick) begin
			next_r.prev_pkg = pkg_min;
			// Drop of more than the step in one ms counts as out of spec
			oos_now = (r.prev_pkg > pkg_min) && ((r.prev_pkg - pkg_min) > OOS_RISE_STEP);
		end
		next_r.thermal_control_circuit = tcc_now;
		for (int t = 0; t < 2; t++) begin
			thr_now[t] = (pkg_min <= r.thr_val[t]);
		end
		next_r.thr_state = thr_now;

		// Reads: reserved bits and unmapped offsets return zero
		unique case (msr_req.addr)
			ADDR_CORE_STATUS: rd_word = status_word(r.s2_temp[msr_req.core], r);
			ADDR_PKG_STATUS: rd_word = status_word(pkg_min, r);
			ADDR_TEMP_REF: rd_word[REF_LSB +: 8] = TJMAX_C;
			ADDR_PWR_RATING: rd_word[PWR_W-1:0] = TDP_UNITS;
			ADDR_THR_CTRL: begin
				rd_word[THR1_LSB +: TEMP_W] = r.thr_val[0];
				rd_word[THR1_EN] = r.thr_en[0];
				rd_word[THR2_LSB +: TEMP_W] = r.thr_val[1];
				rd_word[THR2_EN] = r.thr_en[1];
			end
			ADDR_PWR_CAP: begin
				rd_word[CAP_PL1_LSB +: PWR_W] = r.cap.pl1;
				rd_word[CAP_CLAMP] = r.cap.clamp;
				rd_word[CAP_TIME_LSB +: TIME_W] = r.cap.win;
				rd_word[CAP_PL2_LSB +: PWR_W] = r.cap.pl2;
			end
			default: rd_word = '0;
		endcase
		next_r.ack = msr_req.rd || msr_req.wr;
		if (msr_req.rd) begin
			next_r.rdata = rd_word;
		end

		// Writes of zero clear log bits; writes to read-only offsets drop
		if (msr_req.wr) begin
			unique case (msr_req.addr)
				ADDR_CORE_STATUS, ADDR_PKG_STATUS: begin
					if (!wd[ST_TCC_LOG]) next_r.tcc_log = 1'b0;
					if (!wd[ST_OOS]) next_r.oos = 1'b0;
					if (!wd[ST_THR1_LOG]) next_r.thr_log[0] = 1'b0;
					if (!wd[ST_THR2_LOG]) next_r.thr_log[1] = 1'b0;
				end
				ADDR_THR_CTRL: begin
					next_r.thr_val[0] = wd[THR1_LSB +: TEMP_W];
					next_r.thr_en[0] = wd[THR1_EN];
					next_r.thr_val[1] = wd[THR2_LSB +: TEMP_W];
					next_r.thr_en[1] = wd[THR2_EN];
				end
				ADDR_PWR_CAP: begin
					next_r.cap.pl1 = wd[CAP_PL1_LSB +: PWR_W];
					next_r.cap.clamp = wd[CAP_CLAMP];
					next_r.cap.win = wd[CAP_TIME_LSB +: TIME_W];
					next_r.cap.pl2 = wd[CAP_PL2_LSB +: PWR_W];
				end
				default: begin
				end
			endcase
		end

		// Hardware sets after the clear so a coincident event survives
		if (tcc_now) begin
			next_r.tcc_log = 1'b1;
		end
		if (oos_now) begin
			next_r.oos = 1'b1;
		end
		next_r.irq = 1'b0;
		for (int t = 0; t < 2; t++) begin
			if (thr_now[t] != r.thr_state[t]) begin
				next_r.thr_log[t] = 1'b1;
				if (r.thr_en[t]) begin
					next_r.irq = 1'b1;
				end
			end
		end

		next_r.throttle = r.thermal_control_circuit || gov_long || gov_short;
		next_r.below_base = gov_below;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r <= '0;
			// Syncs start at the coolest reading; zero would fake thermal control activation on release
			r.s1_temp <= '1;
			r.s2_temp <= '1;
			r.avg_st <= AVG_IDLE;
			r.thr_val <= {THR_RESET, THR_RESET};
			r.cap.pl1 <= TDP_UNITS;
			r.cap.win <= TIME_RESET;
			r.cap.pl2 <= PL2_RESET;
		end else begin
			r <= next_r;
		end
	end

	assign msr_rdata = r.rdata;
	assign msr_ack = r.ack;
	assign threshold_irq = r.irq;
	assign throttle_cores = r.throttle;
	assign throttle_gfx = r.throttle;
	assign allow_below_base = r.below_base;
	assign shutdown = r.shutdown;
	assign sideband_temp = r.sideband;
endmodule
`default_nettype wire

// ===== verif/monitor_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module monitor_checker
	import thermal_pkg::*;
#(
	parameter int TICK_LEN = 32
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [NUM_CORES-1:0][TEMP_W-1:0] sensor_reading,
	input wire logic overheat_trip,
	input wire logic turbo_en,
	input wire msr_req_t msr_req,
	input wire logic [63:0] msr_rdata,
	input wire logic msr_ack,
	input wire logic threshold_irq,
	input wire logic throttle_cores,
	input wire logic throttle_gfx,
	input wire logic allow_below_base,
	input wire logic shutdown
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence trip_rise;
		$rose(overheat_trip);
	endsequence
	sequence zero_held;
		(sensor_reading[1] == 7'h00) [*5];
	endsequence
	a_ack_follows_req: assert property ((msr_req.rd || msr_req.wr) |=> msr_ack)
		else $error("ack missing after request");
	a_ack_needs_req: assert property (msr_ack |-> $past(msr_req.rd || msr_req.wr))
		else $error("ack without request");
	a_rdata_holds: assert property (!$past(msr_req.rd) |-> $stable(msr_rdata))
		else $error("read data moved without read");
	a_trip_shuts_down: assert property (trip_rise |-> ##[1:3] shutdown)
		else $error("overheat did not shut down");
	a_shutdown_sticky: assert property (shutdown |=> shutdown)
		else $error("shutdown released");
	a_zero_throttles: assert property (zero_held |-> throttle_cores)
		else $error("zero reading did not throttle");
	a_gfx_with_cores: assert property (throttle_gfx == throttle_cores)
		else $error("graphics throttle differs");
	a_below_needs_turbo: assert property (allow_below_base |-> $past(turbo_en, 2))
		else $error("below base allowed without turbo");
	a_irq_single_pulse: assert property (threshold_irq |=> !threshold_irq)
		else $error("threshold irq repeated");
endmodule
bind thermal_power_limit_monitor monitor_checker #(.TICK_LEN(TICK_LEN)) monitor_checker_i (
	.ref_clk, .rst, .sensor_reading, .overheat_trip, .turbo_en, .msr_req, .msr_rdata,
	.msr_ack, .threshold_irq, .throttle_cores, .throttle_gfx, .allow_below_base, .shutdown);
`default_nettype wire

// ===== verif/host_sw_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_sw_model
	import thermal_pkg::*;
(
	input wire logic ref_clk,
	output var msr_req_t msr_req,
	input wire logic [63:0] msr_rdata,
	input wire logic msr_ack
);
	initial msr_req = '0;
	// One request pulse; a missing ack poisons the returned word
	task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [CORE_W-1:0] c,
		input logic [63:0] d, output logic [63:0] q);
		@(posedge ref_clk);
		msr_req <= '{rd: !w, wr: w, addr: a, core: c, wdata: d};
		@(posedge ref_clk);
		msr_req.rd <= 1'b0;
		msr_req.wr <= 1'b0;
		@(posedge ref_clk);
		q = msr_rdata;
		if (msr_ack !== 1'b1) q = 'x;
	endtask
endmodule
`default_nettype wire

// ===== verif/thermal_power_limit_monitor_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module thermal_power_limit_monitor_test
	import thermal_pkg::*;
;
	localparam int TL = 32;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [NUM_CORES-1:0][TEMP_W-1:0] sensor_reading = {NUM_CORES{7'h20}};
	logic overheat_trip = 1'b0;
	logic [PWR_W-1:0] package_power = '0;
	logic turbo_en = 1'b0;
	msr_req_t msr_req;
	logic [63:0] msr_rdata;
	logic msr_ack, threshold_irq, throttle_cores, throttle_gfx, allow_below_base, shutdown;
	logic [TEMP_W-1:0] sideband_temp;
	logic [63:0] q;
	int bad_count = 0;
	int total_checks = 0;
	always #20 ref_clk = ~ref_clk;
	thermal_power_limit_monitor #(.TICK_LEN(TL)) thermal_power_limit_monitor_i (
		.ref_clk, .rst, .sensor_reading, .overheat_trip, .package_power, .turbo_en, .msr_req,
		.msr_rdata, .msr_ack, .threshold_irq, .throttle_cores, .throttle_gfx,
		.allow_below_base, .shutdown, .sideband_temp);
	host_sw_model host_sw_model_i (.ref_clk, .msr_req, .msr_rdata, .msr_ack);
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task set_all(input logic [TEMP_W-1:0] v);
		sensor_reading <= {NUM_CORES{v}};
	endtask
	task rd(input logic [ADDR_W-1:0] a, input logic [CORE_W-1:0] c);
		host_sw_model_i.access(1'b0, a, c, '0, q);
	endtask
	task wr(input logic [ADDR_W-1:0] a, input logic [63:0] d);
		host_sw_model_i.access(1'b1, a, '0, d, q);
	endtask
	task count_irq(output int n);
		n = 0;
		repeat (16) begin
			@(posedge ref_clk);
			n += int'(threshold_irq === 1'b1);
		end
	endtask
	task t_regs;
		rd(ADDR_PWR_CAP, 0);
		`CHK(q, {17'h0, PL2_RESET, 8'h00, TIME_RESET, 2'b00, TDP_UNITS})
		wr(ADDR_TEMP_REF, '1);
		rd(ADDR_TEMP_REF, 0);
		`CHK(q[REF_LSB+:8], TJMAX_C)
		rd(ADDR_PWR_RATING, 0);
		`CHK(q[14:0], TDP_UNITS)
		rd(12'h123, 0);
		`CHK(q, 64'h0)
	endtask
	task t_core;
		sensor_reading <= {7'h31, 7'h22, 7'h13, 7'h04};
		cyc(4);
		for (int c = 0; c < NUM_CORES; c++) begin
			rd(ADDR_CORE_STATUS, CORE_W'(c));
			`CHK(q[ST_READ_LSB+:TEMP_W], 7'(4 + 15 * c))
		end
	endtask
	task t_thr;
		int n;
		set_all(7'h20);
		cyc(4);
		wr(ADDR_THR_CTRL, (64'h10 << THR1_LSB) | (64'h1 << THR1_EN) | (64'h18 << THR2_LSB));
		rd(ADDR_THR_CTRL, 0);
		`CHK(q, 64'h0000000000189000)
		set_all(7'h08);
		count_irq(n);
		`CHK(n, 1)
		set_all(7'h20);
		count_irq(n);
		`CHK(n, 1)
		rd(ADDR_CORE_STATUS, 0);
		`CHK(q[ST_THR1_LOG], 1'b1)
		`CHK(q[ST_THR2_LOG], 1'b1)
	endtask
	task t_tcc;
		sensor_reading[1] <= 7'h00;
		cyc(5);
		`CHK(throttle_cores, 1'b1)
		`CHK(throttle_gfx, 1'b1)
		rd(ADDR_PKG_STATUS, 0);
		`CHK(q[1:0], 2'b11)
		set_all(7'h30);
		cyc(5);
		`CHK(throttle_cores, 1'b0)
		wr(ADDR_CORE_STATUS, 64'h0);
		rd(ADDR_PKG_STATUS, 0);
		`CHK(q[ST_TCC_LOG], 1'b0)
	endtask
	task t_oos;
		cyc(3 * TL);
		wr(ADDR_PKG_STATUS, 64'h0);
		rd(ADDR_CORE_STATUS, 0);
		`CHK(q[ST_OOS], 1'b0)
		set_all(7'h10);
		cyc(3 * TL);
		rd(ADDR_PKG_STATUS, 0);
		`CHK(q[ST_OOS], 1'b1)
		rd(ADDR_CORE_STATUS, 0);
		`CHK(q[ST_OOS], 1'b1)
	endtask
	task t_gov;
		turbo_en <= 1'b1;
		// Window of 28 seconds, clamp set, long cap under design power
		wr(ADDR_PWR_CAP, {17'h0, PL2_RESET, 8'h00, 7'd28, 2'b10, 15'h0100});
		cyc(3);
		`CHK(allow_below_base, 1'b1)
		turbo_en <= 1'b0;
		cyc(3);
		`CHK(allow_below_base, 1'b0)
		package_power <= 15'h7FFF;
		cyc(5 * TL);
		`CHK(throttle_cores, 1'b0)
		cyc(7 * TL);
		`CHK(throttle_cores, 1'b1)
		package_power <= '0;
		cyc(3 * TL);
		`CHK(throttle_cores, 1'b0)
		// Tiny long cap with a short window must bite only in turbo
		wr(ADDR_PWR_CAP, {17'h0, PL2_RESET, 8'h00, TIME_RESET, 2'b00, 15'h0001});
		package_power <= PL2_RESET;
		turbo_en <= 1'b1;
		cyc(8 * TL);
		`CHK(throttle_cores, 1'b1)
		turbo_en <= 1'b0;
		cyc(3);
		`CHK(throttle_cores, 1'b0)
		package_power <= '0;
	endtask
	task t_side;
		set_all(7'h40);
		cyc(260 * TL);
		`CHK(sideband_temp, 7'h40)
	endtask
	task t_trip;
		overheat_trip <= 1'b1;
		cyc(5);
		`CHK(shutdown, 1'b1)
		overheat_trip <= 1'b0;
		cyc(5);
		`CHK(shutdown, 1'b1)
		rst <= 1'b1;
		cyc(3);
		rst <= 1'b0;
		cyc(2);
		`CHK(shutdown, 1'b0)
	endtask
	task stop_test;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		cyc(16);
		rst <= 1'b0;
		t_regs();
		t_core();
		t_thr();
		t_tcc();
		t_oos();
		t_gov();
		t_side();
		t_trip();
		stop_test();
	end
	// Run needs about 10000 cycles; 25000 leaves room
	initial begin
		#1000000;
		bad_count++;
		stop_test();
	end
endmodule
`default_nettype wire
